//--- rtl/ident_ctrl_cfg.svh
// offsets, field positions, reset values and timing for the ident/control bank
`ifndef IDENT_CTRL_CFG_SVH
`define IDENT_CTRL_CFG_SVH
`define ADDR_W 8
`define OFS_IDENT 8'h00
`define OFS_CTRL 8'h04
`define OFS_HALT_STAT 8'h08
`define ID_FORMAT_VAL 2'h1
`define ID_FORMAT_HI 31
`define ID_FORMAT_LO 30
`define ID_CLASS_HI 27
`define ID_CLASS_LO 16
`define ID_DREV_HI 15
`define ID_DREV_LO 11
`define ID_MAJOR_HI 10
`define ID_MAJOR_LO 8
`define ID_CUSTOM_HI 7
`define ID_CUSTOM_LO 6
`define ID_MINOR_HI 5
`define ID_MINOR_LO 0
`define CTRL_RUN_THROUGH_BIT 0
`define CTRL_GRACEFUL_BIT 1
`define CTRL_FLOW_GATE_BIT 2
`define CTRL_WIDTH 3
`define CTRL_RESET 3'h1
`define SUSP_SYNC_STAGES 2
`endif

//--- rtl/ident_ctrl_pkg.sv
// types shared by the ident/control bank
package ident_ctrl_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_DRAIN = 3'h2,
    ST_HALTED = 3'h4
  } halt_state_e;
endpackage : ident_ctrl_pkg

//--- rtl/level_sync.sv
// two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync (
  input wire logic i_clock, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_level, // asynchronous level
  output logic o_level // synchronised level
);
  logic meta_r;
  // first stage feeds only the second
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_r <= i_level;
      o_level <= meta_r;
    end
  end
endmodule : level_sync

//--- rtl/peripheral_ident_and_control.sv
// identification and control register bank with emulation-suspend gating
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "ident_ctrl_cfg.svh"
module peripheral_ident_and_control #(
  parameter logic [11:0] FUNCTIONAL_CLASS = 12'h123, // arbitrary value
  parameter logic [4:0] DESIGN_REVISION = 5'h01, // arbitrary value
  parameter logic [2:0] MAJOR_REV = 3'h1, // arbitrary value
  parameter logic [1:0] CUSTOM_REV = 2'h0, // arbitrary value
  parameter logic [5:0] MINOR_REV = 6'h01 // arbitrary value
) (
  input wire logic i_clock, // 20 MHz clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic [`ADDR_W-1:0] i_addr, // register byte address
  input wire ident_ctrl_pkg::word_t i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output ident_ctrl_pkg::word_t o_rdata, // read data, cycle after strobe
  input wire logic i_emu_suspend, // emulation suspend pin, async
  input wire logic i_tx_req, // logical layer wants to start a transmit
  input wire logic i_tx_busy, // a transmit transfer is in progress
  input wire logic i_rx_req, // incoming request at logical layer
  input wire logic i_rx_busy, // an incoming transfer is in progress
  output logic o_tx_start, // transmit start granted
  output logic o_rx_accept, // incoming request accepted
  output logic o_rx_refuse, // incoming request refused
  output logic o_flow_enable, // flow gate state
  output logic o_halted // suspend fully honoured
);
  import ident_ctrl_pkg::*;

  // register map, byte offsets on the host register port:
  //   0x00 identification word, constant, writes dropped
  //   0x04 control word, three live bits, the rest read zero
  //   0x08 halt status, one-hot sequencer state, read only
  //   anything else reads zero and ignores writes
  // control bits:
  //   bit 0 run-through: suspend pin ignored while set, resets set
  //   bit 1 graceful-halt: selects soft stop when set
  //   bit 2 flow gate: logical layer traffic allowed when set, resets clear
  // the bank never stalls the host; every access finishes in one cycle,
  // which keeps the host side free of any wait logic.
  // the halt sequencer only blocks new starts; it never cuts a transfer
  // short, so a long transfer simply stretches the drain phase.

  logic [`CTRL_WIDTH-1:0] ctrl_r;
  halt_state_e halt_r;
  halt_state_e halt_nxt;
  word_t rdata_nxt;
  logic susp_sync;
  logic susp_active;
  logic busy;
  logic start_ok;
  word_t ident_word;

  // decode of a register address, used for reads and writes
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // constant identification word
  always_comb begin
    ident_word = '0;
    ident_word[`ID_FORMAT_HI:`ID_FORMAT_LO] = `ID_FORMAT_VAL;
    ident_word[`ID_CLASS_HI:`ID_CLASS_LO] = FUNCTIONAL_CLASS;
    ident_word[`ID_DREV_HI:`ID_DREV_LO] = DESIGN_REVISION;
    ident_word[`ID_MAJOR_HI:`ID_MAJOR_LO] = MAJOR_REV;
    ident_word[`ID_CUSTOM_HI:`ID_CUSTOM_LO] = CUSTOM_REV;
    ident_word[`ID_MINOR_HI:`ID_MINOR_LO] = MINOR_REV;
  end

  // suspend pin is asynchronous, so synchronise before use
  level_sync u_susp_sync (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_level(i_emu_suspend),
    .o_level(susp_sync)
  );

  // control register; only the three low bits exist
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (i_wr && hit(i_addr, `OFS_CTRL)) begin
      ctrl_r <= i_wdata[`CTRL_WIDTH-1:0];
    end
  end

  // read mux; writes to the ident word fall through harmlessly
  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      if (hit(i_addr, `OFS_IDENT)) begin
        rdata_nxt = ident_word;
      end else if (hit(i_addr, `OFS_CTRL)) begin
        rdata_nxt = {29'h0, ctrl_r};
      end else if (hit(i_addr, `OFS_HALT_STAT)) begin
        rdata_nxt = {29'h0, halt_r};
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= rdata_nxt;
    end
  end

  // suspend counts only with run-through clear
  // hard stop is unsupported, so graceful-halt 0 is treated as soft stop too
  assign susp_active = susp_sync && !ctrl_r[`CTRL_RUN_THROUGH_BIT];
  assign busy = i_tx_busy || i_rx_busy;

  // halt sequencing: drain running work then hold
  always_comb begin
    case (halt_r)
      ST_RUN: halt_nxt = susp_active ? (busy ? ST_DRAIN : ST_HALTED) : ST_RUN;
      ST_DRAIN: begin
        if (!susp_active) begin
          halt_nxt = ST_RUN;
        end else if (!busy) begin
          halt_nxt = ST_HALTED;
        end else begin
          halt_nxt = ST_DRAIN;
        end
      end
      ST_HALTED: halt_nxt = susp_active ? ST_HALTED : ST_RUN;
      default: halt_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      halt_r <= ST_RUN;
    end else begin
      halt_r <= halt_nxt;
    end
  end

  // new starts need the flow gate and no suspend in force
  assign start_ok = ctrl_r[`CTRL_FLOW_GATE_BIT] && !susp_active && (halt_r == ST_RUN);
  assign o_tx_start = i_tx_req && start_ok;
  assign o_rx_accept = i_rx_req && start_ok;
  assign o_rx_refuse = i_rx_req && !start_ok;
  assign o_flow_enable = ctrl_r[`CTRL_FLOW_GATE_BIT];
  assign o_halted = (halt_r == ST_HALTED);

  chk_gate_blocks_tx: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !ctrl_r[`CTRL_FLOW_GATE_BIT] |-> !o_tx_start)
    else $error("transmit started with flow gate clear");

  chk_gate_refuses_rx: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rx_req && !ctrl_r[`CTRL_FLOW_GATE_BIT]) |-> (o_rx_refuse && !o_rx_accept))
    else $error("request not refused with flow gate clear");

  chk_gate_write_one: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_wr && i_addr == `OFS_CTRL && i_wdata[`CTRL_FLOW_GATE_BIT]) |=> o_flow_enable)
    else $error("flow gate did not set on write");

  chk_ident_constant: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_IDENT) |=> (o_rdata == ident_word))
    else $error("ident word read differs from constant");

  chk_ident_format: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_IDENT) |=> (o_rdata[31:30] == 2'h1 && o_rdata[29:28] == 2'h0))
    else $error("format field wrong");

  chk_ctrl_upper_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_CTRL) |=> (o_rdata[31:3] == 29'h0))
    else $error("control upper bits not zero");

  chk_free_ignores: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ctrl_r[`CTRL_RUN_THROUGH_BIT] |=> !o_halted || !$past(ctrl_r[`CTRL_RUN_THROUGH_BIT]))
    else $error("halted while run-through set");

  chk_soft_drains: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (susp_active && busy && halt_r == ST_DRAIN) |=> !o_halted)
    else $error("halted before transfers finished");

  chk_suspend_halts: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (susp_active && !busy)[*2] |-> o_halted)
    else $error("idle suspend did not halt");

  // read data returns to zero in every cycle that follows no read
  chk_rdata_idle_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !i_rd |=> (o_rdata == 32'h0))
    else $error("read data not zero outside read");

  // class field carries the configured value
  chk_ident_class: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_IDENT) |=> (o_rdata[27:16] == FUNCTIONAL_CLASS))
    else $error("class field wrong");

  // revision fields sit in their documented order
  chk_ident_revs: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_IDENT) |=>
      (o_rdata[15:0] == {DESIGN_REVISION, MAJOR_REV, CUSTOM_REV, MINOR_REV}))
    else $error("revision fields wrong");

  // a control read returns the live bits as they stood at the strobe
  chk_ctrl_readback: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_CTRL) |=> (o_rdata[2:0] == $past(ctrl_r)))
    else $error("control read back wrong");

  // control word moves only on a write to its own offset
  chk_ctrl_holds: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !(i_wr && i_addr == `OFS_CTRL) |=> $stable(ctrl_r))
    else $error("control changed without a write");

  // a control write keeps exactly the three live bits
  chk_ctrl_write_takes: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_wr && i_addr == `OFS_CTRL) |=> (ctrl_r == $past(i_wdata[2:0])))
    else $error("control write not taken");

  // writing zero to the gate closes it again
  chk_gate_write_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_wr && i_addr == `OFS_CTRL && !i_wdata[`CTRL_FLOW_GATE_BIT]) |=> !o_flow_enable)
    else $error("flow gate did not clear on write");

  // closed gate never accepts an incoming request
  chk_gate_blocks_accept: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    !ctrl_r[`CTRL_FLOW_GATE_BIT] |-> !o_rx_accept)
    else $error("request accepted with flow gate clear");

  // open gate with no suspend handles requests normally
  chk_gate_open_accepts: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (ctrl_r[`CTRL_FLOW_GATE_BIT] && !susp_active && halt_r == ST_RUN && i_rx_req) |->
      (o_rx_accept && !o_rx_refuse))
    else $error("request not accepted with gate open");

  // open gate with no suspend lets transmits start
  chk_open_starts_tx: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (ctrl_r[`CTRL_FLOW_GATE_BIT] && !susp_active && halt_r == ST_RUN && i_tx_req) |->
      o_tx_start)
    else $error("transmit withheld with gate open");

  // a start is only ever granted against a request
  chk_tx_needs_req: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_tx_start |-> i_tx_req)
    else $error("transmit start without request");

  // no answer comes unasked, and accept and refuse never come together
  chk_rx_exclusive: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (o_rx_accept || o_rx_refuse) |-> (i_rx_req && (o_rx_accept != o_rx_refuse)))
    else $error("accept and refuse not exclusive");

  // draining or halted: no new work of either kind
  chk_halt_blocks_starts: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (halt_r != ST_RUN) |-> (!o_tx_start && !o_rx_accept))
    else $error("new start while draining or halted");

  // a suspend in force blocks new starts at once
  chk_suspend_blocks: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    susp_active |-> (!o_tx_start && !o_rx_accept))
    else $error("new start while suspend in force");

  // run-through set masks the pin completely
  chk_free_no_suspend: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    ctrl_r[`CTRL_RUN_THROUGH_BIT] |-> !susp_active)
    else $error("suspend seen with run-through set");

  // release of the suspend returns to normal work after one cycle
  chk_release_resumes: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (!susp_active && halt_r != ST_RUN) |=> (halt_r == ST_RUN))
    else $error("did not resume after release");

  // drain holds while transfers remain in flight
  chk_drain_waits: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (halt_r == ST_DRAIN && busy && susp_active) |=> (halt_r == ST_DRAIN))
    else $error("drain left with transfers in flight");

  // graceful-halt clear still stops softly, since hard stop is absent
  chk_hard_as_soft: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (susp_active && !ctrl_r[`CTRL_GRACEFUL_BIT] && !busy && halt_r != ST_RUN) |=> o_halted)
    else $error("graceful-halt clear did not stop softly");

  // halt is only reached through a suspend in force
  chk_halt_needs_suspend: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    o_halted |-> $past(susp_active))
    else $error("halted without suspend");

  // sequencer state stays one-hot
  chk_state_onehot: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    $onehot(halt_r))
    else $error("halt state not one-hot");

  // status read shows the sequencer state at the strobe
  chk_halt_stat_read: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr == `OFS_HALT_STAT) |=> (o_rdata == {29'h0, $past(halt_r)}))
    else $error("halt status read wrong");

  // holes in the map read zero
  chk_unmapped_zero: assert property (@(posedge i_clock) disable iff (!i_arst_n)
    (i_rd && i_addr != `OFS_IDENT && i_addr != `OFS_CTRL && i_addr != `OFS_HALT_STAT) |=>
      (o_rdata == 32'h0))
    else $error("unmapped read not zero");

  // every reserved control bit, one at a time, so a single stuck bit is named
  for (genvar b = `CTRL_WIDTH; b < 32; b++) begin : g_rsvd
    chk_rsvd_bit: assert property (@(posedge i_clock) disable iff (!i_arst_n)
      (i_rd && i_addr == `OFS_CTRL) |=> !o_rdata[b])
      else $error("reserved control bit set");
  end
endmodule : peripheral_ident_and_control

//--- tb/peripheral_ident_and_control_test.sv
// self-checking bench for the ident/control register bank
`timescale 1ns/1ps
`include "ident_ctrl_cfg.svh"
module peripheral_ident_and_control_test;
  import ident_ctrl_pkg::*;
  localparam logic [11:0] CLS = 12'h5a6; // arbitrary value
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b0;
  logic [`ADDR_W-1:0] i_addr = 8'h00;
  word_t i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_emu_suspend = 1'b0;
  logic i_tx_req = 1'b0, i_tx_busy = 1'b0, i_rx_req = 1'b0, i_rx_busy = 1'b0;
  word_t o_rdata, rd_val, w;
  logic o_tx_start, o_rx_accept, o_rx_refuse, o_flow_enable, o_halted;
  int error_cnt = 0, comparisons = 0, cycles = 0;
  // ident values differ from the defaults so a hardwired constant shows up
  peripheral_ident_and_control #(.FUNCTIONAL_CLASS(CLS), .DESIGN_REVISION(5'h0b),
    .MAJOR_REV(3'h5), .CUSTOM_REV(2'h2), .MINOR_REV(6'h2a)) u_dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_emu_suspend(i_emu_suspend),
    .i_tx_req(i_tx_req), .i_tx_busy(i_tx_busy), .i_rx_req(i_rx_req), .i_rx_busy(i_rx_busy),
    .o_tx_start(o_tx_start), .o_rx_accept(o_rx_accept), .o_rx_refuse(o_rx_refuse),
    .o_flow_enable(o_flow_enable), .o_halted(o_halted));
  always #25 i_clock = ~i_clock;
  function automatic word_t ident_exp();
    return {`ID_FORMAT_VAL, 2'h0, CLS, 5'h0b, 3'h5, 2'h2, 6'h2a};
  endfunction : ident_exp
  task automatic check(input word_t seen, input word_t exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input word_t d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe is taken
  task automatic rd(input logic [7:0] a, output word_t v);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_cyc
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  // hang guard, run needs under two hundred cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(64876));
    repeat (16) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(`OFS_IDENT, rd_val);
    check(rd_val, ident_exp());
    rd(`OFS_CTRL, rd_val);
    check(rd_val, 32'h1);
    check(o_flow_enable, 32'h0);
    $display("test reset values done");
    // random writes, ident must not move, reserved control bits stay zero
    for (int k = 0; k < 9; k++) begin
      w = (k == 0) ? 32'hffff_fff8 : $urandom();
      wr(`OFS_IDENT, w);
      rd(`OFS_IDENT, rd_val);
      check(rd_val, ident_exp());
      wr(`OFS_CTRL, w);
      rd(`OFS_CTRL, rd_val);
      check(rd_val, w & 32'h7);
      check(o_flow_enable, w[2]);
      rd(8'h0c, rd_val);
      check(rd_val, 32'h0);
    end
    $display("test register access done");
    // gate closed then open, requests at random
    for (int g = 0; g < 2; g++) begin
      wr(`OFS_CTRL, g ? 32'h5 : 32'h1);
      for (int k = 0; k < 8; k++) begin
        @(posedge i_clock);
        {i_tx_req, i_rx_req} <= 2'($urandom());
        #1;
        check(o_tx_start, i_tx_req & g[0]);
        check(o_rx_accept, i_rx_req & g[0]);
        check(o_rx_refuse, i_rx_req & ~g[0]);
      end
    end
    $display("test flow gate done");
    // run-through set: suspend has no effect
    @(posedge i_clock);
    i_tx_req <= 1'b1;
    i_emu_suspend <= 1'b1;
    wait_cyc(6);
    check(o_halted, 32'h0);
    check(o_tx_start, 32'h1);
    // soft stop with a transfer in flight
    @(posedge i_clock);
    i_tx_busy <= 1'b1;
    wr(`OFS_CTRL, 32'h6);
    wait_cyc(6);
    check(o_tx_start, 32'h0);
    check(o_halted, 32'h0);
    @(posedge i_clock);
    i_tx_busy <= 1'b0;
    wait_cyc(3);
    check(o_halted, 32'h1);
    rd(`OFS_HALT_STAT, rd_val);
    check(rd_val, 32'h4);
    @(posedge i_clock);
    i_emu_suspend <= 1'b0;
    wait_cyc(5);
    check(o_halted, 32'h0);
    check(o_tx_start, 32'h1);
    $display("test suspend done");
    // graceful-halt clear behaves as soft stop
    wr(`OFS_CTRL, 32'h4);
    @(posedge i_clock);
    i_emu_suspend <= 1'b1;
    wait_cyc(5);
    check(o_halted, 32'h1);
    check(o_tx_start, 32'h0);
    @(posedge i_clock);
    i_emu_suspend <= 1'b0;
    wait_cyc(5);
    check(o_halted, 32'h0);
    $display("test hard stop setting done");
    // reset again in mid-run, control must return to its reset value
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rd(`OFS_CTRL, rd_val);
    check(rd_val, 32'h1);
    check(o_flow_enable, 32'h0);
    check(o_tx_start, 32'h0);
    $display("test second reset done");
    complete_run();
  end
endmodule : peripheral_ident_and_control_test
